// ---- fpec_top.v ----
// Flash program/erase control: interlocked control register, latches, high-voltage gating and test register.
// Functional notes
// - Capture next valid write; protect boot block.
// - Boot block erased only when protect clear.
// - High voltage only with enable and supply.
// - Pulse enable refused until latches loaded.
// - Latches load only while latch enable set.
// - Latch and pulse enable need separate writes.
// - Mode bits frozen while pulse enable set.
// - Stop or wait aborts programming immediately.
// - Test bits writable only in special mode.
// - Normal operation until test function invoked.
// - Array reads ignored while pulse enable set.
// - Further array writes ignored once latched.
`timescale 1ns/1ps
`include "fpec_defines.vh"
module fpec_top #(
    parameter ADDR_W = 15,
    parameter DATA_W = 16,
    parameter [ADDR_W-1:0] ARRAY_LAST = 15'h7FFF,
    parameter [ADDR_W-1:0] BOOT_FIRST = 15'h7800
) (
    input wire CLK, // Bus clock, 25 MHz.
    input wire SYS_RST, // Synchronous reset, active high.
    input wire CE, // Clock enable; low freezes all state.
    input wire [3:0] AVS_ADDRESS, // Register byte address.
    input wire AVS_READ, // Register read request.
    input wire AVS_WRITE, // Register write request.
    input wire [31:0] AVS_WRITEDATA, // Register write data.
    output wire [31:0] AVS_READDATA, // Register read data.
    output wire AVS_WAITREQUEST, // Stall until the access is taken.
    input wire ARRAY_WR, // Array write cycle strobe.
    input wire ARRAY_RD, // Array read cycle strobe.
    input wire [ADDR_W-1:0] ARRAY_ADDR, // Array cycle address.
    input wire [DATA_W-1:0] ARRAY_WDATA, // Array write data.
    input wire SUPPLY_OK, // Programming supply present.
    input wire STOP_WAIT, // Processor in stop or wait mode.
    input wire SPECIAL_MODE, // Special mode line.
    output wire HV_PROGRAM, // Program voltage routed to the array.
    output wire HV_ERASE, // Erase voltage routed to the array.
    output wire ERASE_BOOT, // Boot block included in the erase.
    output wire [ADDR_W-1:0] PROG_ADDR, // Latched programming address.
    output wire [DATA_W-1:0] PROG_DATA, // Latched programming data.
    output wire READ_IGNORE, // Array read cycle must be ignored.
    output wire READ_LATCHED, // Array read returns the latched location.
    output wire WAKE_DELAY, // Wake delay select to the array timing.
    output wire [7:0] TEST_CTRL // Test function controls.
);
    reg hv_reg;
    reg hv_next;
    reg lat_reg;
    reg lat_next;
    reg ers_reg;
    reg ers_next;
    reg bbp_reg;
    reg bbp_next;
    reg wds_reg;
    reg wds_next;
    reg ack_reg;
    reg [31:0] rdata_reg;
    reg [31:0] rdata_next;
    wire req;
    wire take;
    wire ctrl_we;
    wire test_we;
    wire in_array;
    wire in_boot;
    wire prog_block;
    wire loaded;
    wire [7:0] test_val;
    wire [7:0] ctrl_val;
    wire [7:0] stat_val;
    wire [7:0] wb;
    wire hv_live;
    // Reset value as a sized word, so that each bit is taken by index and no width is cut.
    localparam [7:0] ctrl_rst_val = `FPEC_CTRL_RST;

    // One wait cycle per access: the answer is ready at the second edge.
    assign req = AVS_READ | AVS_WRITE;
    assign take = req & ack_reg & CE;
    assign AVS_WAITREQUEST = req & ~take;
    assign AVS_READDATA = rdata_reg;
    assign ctrl_we = take & AVS_WRITE & (AVS_ADDRESS == `FPEC_OFS_CTRL);
    assign test_we = take & AVS_WRITE & (AVS_ADDRESS == `FPEC_OFS_TEST);
    assign wb = AVS_WRITEDATA[7:0];

    always @(posedge CLK) begin
        if (SYS_RST) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else if (CE) begin
            ack_reg <= req & ~ack_reg;
            rdata_reg <= rdata_next;
        end
    end

    assign ctrl_val = {3'h0, wds_reg, bbp_reg, ers_reg, lat_reg, hv_reg};
    assign stat_val = {2'h0, |test_val, hv_live, SPECIAL_MODE, STOP_WAIT, SUPPLY_OK, loaded};

    always @* begin
        rdata_next = 32'h00000000;
        if (req && !ack_reg) begin
            case (AVS_ADDRESS)
                `FPEC_OFS_CTRL: rdata_next = {24'h000000, ctrl_val};
                `FPEC_OFS_TEST: rdata_next = {24'h000000, test_val};
                `FPEC_OFS_STAT: rdata_next = {24'h000000, stat_val};
                default: rdata_next = 32'h00000000;
            endcase
        end else if (ack_reg) begin
            rdata_next = rdata_reg;
        end
    end

    // Control register write interlocks.
    always @* begin
        hv_next = hv_reg;
        lat_next = lat_reg;
        ers_next = ers_reg;
        bbp_next = bbp_reg;
        wds_next = wds_reg;
        if (ctrl_we) begin
            wds_next = wb[`FPEC_BIT_WDS];
            if (hv_reg) begin
                // Only the pulse enable and the wake delay select may change while voltage is applied.
                hv_next = wb[`FPEC_BIT_HV] & wb[`FPEC_BIT_LAT];
            end else begin
                ers_next = wb[`FPEC_BIT_ERS];
                bbp_next = wb[`FPEC_BIT_BBP];
                // The supply detector stops latch enable from rising without the supply.
                lat_next = wb[`FPEC_BIT_LAT] & (SUPPLY_OK | lat_reg);
                // A prior loading write is needed, so latch and pulse enable cannot arrive together.
                hv_next = wb[`FPEC_BIT_HV] & wb[`FPEC_BIT_LAT] & lat_reg & loaded;
            end
        end
        if (STOP_WAIT) begin
            hv_next = 1'b0;
        end
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            hv_reg <= ctrl_rst_val[`FPEC_BIT_HV];
            lat_reg <= ctrl_rst_val[`FPEC_BIT_LAT];
            ers_reg <= ctrl_rst_val[`FPEC_BIT_ERS];
            bbp_reg <= ctrl_rst_val[`FPEC_BIT_BBP];
            wds_reg <= ctrl_rst_val[`FPEC_BIT_WDS];
        end else if (CE) begin
            hv_reg <= hv_next;
            lat_reg <= lat_next;
            ers_reg <= ers_next;
            bbp_reg <= bbp_next;
            wds_reg <= wds_next;
        end
    end

    assign in_array = (ARRAY_ADDR <= ARRAY_LAST);
    assign in_boot = (ARRAY_ADDR >= BOOT_FIRST) && in_array;
    // Erase arming writes are never blocked; only programming of a protected boot address is.
    assign prog_block = bbp_reg & ~ers_reg & in_boot;

    fpec_latch #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_latch (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .latch_en(lat_reg),
        .wr(ARRAY_WR & ~hv_reg),
        .addr_ok(in_array),
        .block(prog_block),
        .addr(ARRAY_ADDR),
        .data(ARRAY_WDATA),
        .loaded(loaded),
        .addr_q(PROG_ADDR),
        .data_q(PROG_DATA)
    );

    fpec_testreg #(
        .W(8)
    ) u_test (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .special(SPECIAL_MODE),
        .we(test_we),
        .wdata(wb),
        .value(test_val)
    );

    // Voltage is cut combinationally so stop or a lost supply acts at once, not a cycle later.
    assign hv_live = hv_reg & lat_reg & loaded & SUPPLY_OK & ~STOP_WAIT;
    assign HV_PROGRAM = hv_live & ~ers_reg;
    assign HV_ERASE = hv_live & ers_reg;
    assign ERASE_BOOT = HV_ERASE & ~bbp_reg;
    assign READ_IGNORE = ARRAY_RD & hv_reg;
    assign READ_LATCHED = ARRAY_RD & ~hv_reg & lat_reg & ~ers_reg;
    assign WAKE_DELAY = wds_reg;
    // Test bits clear at the first enabled edge outside special mode, so normal behaviour holds until one is set.
    assign TEST_CTRL = test_val;
endmodule // fpec_top

// ---- fpec_defines.vh ----
// Register map, field positions and reset values of the flash program/erase control block.
`ifndef FPEC_DEFINES_VH
`define FPEC_DEFINES_VH

`define FPEC_OFS_CTRL 4'h0
`define FPEC_OFS_TEST 4'h4
`define FPEC_OFS_STAT 4'h8

`define FPEC_BIT_HV 0
`define FPEC_BIT_LAT 1
`define FPEC_BIT_ERS 2
`define FPEC_BIT_BBP 3
`define FPEC_BIT_WDS 4

`define FPEC_CTRL_RST 8'h08
`define FPEC_TEST_RST 8'h00

`define FPEC_ST_LATCHED 0
`define FPEC_ST_SUPPLY 1
`define FPEC_ST_STOPWAIT 2
`define FPEC_ST_SPECIAL 3
`define FPEC_ST_HV_ON 4
`define FPEC_ST_TEST_ON 5

`endif

// ---- fpec_latch.v ----
// Programming address and data latches with the loaded flag.
`timescale 1ns/1ps
module fpec_latch #(
    parameter ADDR_W = 15,
    parameter DATA_W = 16
) (
    input wire clk, // Bus clock.
    input wire rst, // Synchronous reset, active high.
    input wire ce, // Clock enable.
    input wire latch_en, // Latches enabled.
    input wire wr, // Array write strobe.
    input wire addr_ok, // Address lies inside the array.
    input wire block, // Write refused by boot protection.
    input wire [ADDR_W-1:0] addr, // Array write address.
    input wire [DATA_W-1:0] data, // Array write data.
    output reg loaded, // Latches hold a valid write.
    output reg [ADDR_W-1:0] addr_q, // Latched address.
    output reg [DATA_W-1:0] data_q // Latched data.
);
    always @(posedge clk) begin
        if (rst) begin
            loaded <= 1'b0;
            addr_q <= {ADDR_W{1'b0}};
            data_q <= {DATA_W{1'b0}};
        end else if (ce) begin
            if (!latch_en) begin
                loaded <= 1'b0;
            end else if (wr && addr_ok && !loaded && !block) begin
                // Only the first valid write after enabling is kept; later ones are ignored.
                loaded <= 1'b1;
                addr_q <= addr;
                data_q <= data;
            end
        end
    end
endmodule // fpec_latch

// ---- fpec_testreg.v ----
// Test control register that exists only while the special mode line is asserted.
`timescale 1ns/1ps
`include "fpec_defines.vh"
module fpec_testreg #(
    parameter W = 8
) (
    input wire clk, // Bus clock.
    input wire rst, // Synchronous reset, active high.
    input wire ce, // Clock enable.
    input wire special, // Special mode line.
    input wire we, // Write strobe for this register.
    input wire [W-1:0] wdata, // Write data.
    output reg [W-1:0] value // Current test bits.
);
    always @(posedge clk) begin
        if (rst) begin
            value <= `FPEC_TEST_RST;
        end else if (ce) begin
            if (!special) begin
                value <= {W{1'b0}};
            end else if (we) begin
                value <= wdata;
            end
        end
    end
endmodule // fpec_testreg

// ---- fpec_props.sv ----
// Port-level assertions for the flash program/erase control block.
`timescale 1ns/1ps
module fpec_props #(parameter ADDR_W = 15) (
    input wire CLK, // Bus clock.
    input wire SYS_RST, // Synchronous reset, active high.
    input wire CE, // Clock enable.
    input wire AVS_READ, // Register read request.
    input wire AVS_WRITE, // Register write request.
    input wire AVS_WAITREQUEST, // Bus stall.
    input wire [31:0] AVS_READDATA, // Register read data.
    input wire ARRAY_WR, // Array write strobe.
    input wire ARRAY_RD, // Array read strobe.
    input wire SUPPLY_OK, // Programming supply present.
    input wire STOP_WAIT, // Stop or wait mode.
    input wire SPECIAL_MODE, // Special mode line.
    input wire HV_PROGRAM, // Program voltage on.
    input wire HV_ERASE, // Erase voltage on.
    input wire ERASE_BOOT, // Boot block in the erase.
    input wire READ_IGNORE, // Array read ignored.
    input wire [ADDR_W-1:0] PROG_ADDR, // Latched address.
    input wire [7:0] TEST_CTRL // Test controls.
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // A frozen clock enable stretches the wait, so only running cycles are counted.
    sequence s_req; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE; endsequence
    sequence s_off2; !SPECIAL_MODE && CE ##1 !SPECIAL_MODE; endsequence
    property p_one_wait; s_req ##1 CE |-> !AVS_WAITREQUEST; endproperty
    property p_rd_hi; AVS_READDATA[31:8] == 24'h0; endproperty
    property p_supply; HV_PROGRAM || HV_ERASE |-> SUPPLY_OK; endproperty
    property p_stop; STOP_WAIT |-> !HV_PROGRAM && !HV_ERASE; endproperty
    property p_hold; HV_PROGRAM || HV_ERASE |=> $stable(PROG_ADDR); endproperty
    property p_boot; ERASE_BOOT |-> HV_ERASE; endproperty
    property p_rd_ign; ARRAY_RD && (HV_PROGRAM || HV_ERASE) |-> READ_IGNORE; endproperty
    property p_src; !$stable(PROG_ADDR) |-> $past(ARRAY_WR); endproperty
    property p_test_off; s_off2 |-> TEST_CTRL == 8'h00; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
    a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
    a_supply: assert property (p_supply) else $error("high voltage without supply");
    a_stop: assert property (p_stop) else $error("high voltage in stop or wait");
    a_hold: assert property (p_hold) else $error("latch moved under high voltage");
    a_boot: assert property (p_boot) else $error("boot erase outside erase");
    a_rd_ign: assert property (p_rd_ign) else $error("read not ignored");
    a_src: assert property (p_src) else $error("latch moved without array write");
    a_test_off: assert property (p_test_off) else $error("test bits outside special mode");
endmodule // fpec_props
bind fpec_top fpec_props #(.ADDR_W(ADDR_W)) u_props (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .CE(CE),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AVS_READDATA(AVS_READDATA),
    .ARRAY_WR(ARRAY_WR),
    .ARRAY_RD(ARRAY_RD),
    .SUPPLY_OK(SUPPLY_OK),
    .STOP_WAIT(STOP_WAIT),
    .SPECIAL_MODE(SPECIAL_MODE),
    .HV_PROGRAM(HV_PROGRAM),
    .HV_ERASE(HV_ERASE),
    .ERASE_BOOT(ERASE_BOOT),
    .READ_IGNORE(READ_IGNORE),
    .PROG_ADDR(PROG_ADDR),
    .TEST_CTRL(TEST_CTRL)
);

// ---- test_flash_program_erase_control.sv ----
// Self-checking bench for the flash program/erase control block.
`timescale 1ns/1ps
`include "fpec_defines.vh"
module test_flash_program_erase_control;
    localparam [3:0] CT = `FPEC_OFS_CTRL, TS = `FPEC_OFS_TEST, ST = `FPEC_OFS_STAT;
    localparam [2:0] P_HVP = 3'h0, P_HVE = 3'h1, P_EB = 3'h2, P_IGN = 3'h3, P_LAT = 3'h4, P_WDL = 3'h5;
    reg clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, awr = 1'b0, ard = 1'b0, sup = 1'b0, stp = 1'b0, spc = 1'b0;
    reg ce = 1'b1;
    reg [3:0] adr = 4'h0;
    reg [31:0] wd = 32'h0, got;
    reg [14:0] aa = 15'h0;
    reg [15:0] ad = 16'h0;
    wire [31:0] rdata;
    wire wq, hvp, hve, eb, rign, rlat, wdly;
    wire [14:0] pa;
    wire [15:0] pd;
    wire [7:0] tc;
    integer n_mismatch = 0, cmp_count = 0, cyc = 0;
    always #20 clk = ~clk;
    fpec_top i_dut (.CLK(clk), .SYS_RST(rst), .CE(ce), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq), .ARRAY_WR(awr), .ARRAY_RD(ard),
        .ARRAY_ADDR(aa), .ARRAY_WDATA(ad), .SUPPLY_OK(sup), .STOP_WAIT(stp), .SPECIAL_MODE(spc),
        .HV_PROGRAM(hvp), .HV_ERASE(hve), .ERASE_BOOT(eb), .PROG_ADDR(pa), .PROG_DATA(pd),
        .READ_IGNORE(rign), .READ_LATCHED(rlat), .WAKE_DELAY(wdly), .TEST_CTRL(tc));
    task test_done; begin
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end endtask
    task chk(input [31:0] g, input [31:0] e); begin
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    end endtask
    // The request stands until waitrequest is seen low at a rising edge; that edge takes it and the read data.
    // One idle edge follows, so the next call never drives the strobes twice in one time step.
    task bus(input w, input [3:0] a, input [7:0] d); begin
        rd <= !w; wr <= w; adr <= a; wd <= {24'h0, d};
        @(posedge clk);
        while (wq !== 1'b0) begin
            @(posedge clk);
        end
        got = rdata;
        rd <= 1'b0; wr <= 1'b0;
        @(posedge clk);
    end endtask
    task wreg(input [3:0] a, input [7:0] d); bus(1'b1, a, d); endtask
    task rchk(input [3:0] a, input [7:0] e); begin
        bus(1'b0, a, 8'h00);
        chk(got, {24'h0, e});
    end endtask
    task arr(input [14:0] a, input [15:0] d); begin
        awr <= 1'b1; aa <= a; ad <= d;
        @(posedge clk);
        awr <= 1'b0;
        @(posedge clk);
    end endtask
    // The pin is chosen by code and read at the falling edge, after the stimulus of the rising edge has settled.
    task pin(input [2:0] s, input e); begin
        @(negedge clk);
        case (s)
            P_HVP: chk(hvp, e);
            P_HVE: chk(hve, e);
            P_EB: chk(eb, e);
            P_IGN: chk(rign, e);
            P_LAT: chk(rlat, e);
            default: chk(wdly, e);
        endcase
        @(posedge clk);
    end endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0; sup <= 1'b1;
        rchk(CT, 8'h08);
        rchk(4'hC, 8'h00);
        wreg(CT, 8'h01);
        rchk(CT, 8'h00);
        wreg(CT, 8'h03);
        rchk(CT, 8'h02);
        $display("interlock test done");
        arr(15'h1234, 16'hBEEF);
        rchk(ST, 8'h03);
        arr(15'h0100, 16'h0000);
        chk(pa, 15'h1234);
        chk(pd, 16'hBEEF);
        wreg(CT, 8'h03);
        pin(P_HVP, 1'b1);
        // Writing the pulse bit with latch enable clear ends the pulse; latch enable and the mode bits stay.
        wreg(CT, 8'h05);
        rchk(CT, 8'h02);
        wreg(CT, 8'h03);
        ard <= 1'b1;
        pin(P_IGN, 1'b1);
        ard <= 1'b0; sup <= 1'b0;
        pin(P_HVP, 1'b0);
        sup <= 1'b1; stp <= 1'b1;
        pin(P_HVP, 1'b0);
        stp <= 1'b0;
        rchk(CT, 8'h02);
        ard <= 1'b1;
        pin(P_LAT, 1'b1);
        ard <= 1'b0;
        wreg(CT, 8'h03);
        repeat (4) @(posedge clk);
        pin(P_HVP, 1'b1);
        wreg(CT, 8'h02);
        pin(P_HVP, 1'b0);
        wreg(CT, 8'h03);
        wreg(CT, 8'h02);
        rchk(CT, 8'h02);
        wreg(CT, 8'h0A);
        $display("program test done");
        wreg(CT, 8'h08);
        wreg(CT, 8'h0A);
        arr(15'h7800, 16'h1111);
        rchk(ST, 8'h02);
        wreg(CT, 8'h0B);
        rchk(CT, 8'h0A);
        wreg(CT, 8'h0E);
        arr(15'h7900, 16'h0000);
        wreg(CT, 8'h0F);
        pin(P_EB, 1'b0);
        pin(P_HVE, 1'b1);
        wreg(CT, 8'h0E);
        wreg(CT, 8'h06);
        wreg(CT, 8'h07);
        pin(P_EB, 1'b1);
        wreg(CT, 8'h16);
        wreg(CT, 8'h10);
        pin(P_WDL, 1'b1);
        $display("erase test done");
        wreg(TS, 8'h5A);
        rchk(TS, 8'h00);
        spc <= 1'b1;
        wreg(TS, 8'h5A);
        rchk(TS, 8'h5A);
        chk(tc, 8'h5A);
        // With the clock enable low the test bits must not clear, even though special mode has gone.
        ce <= 1'b0; spc <= 1'b0;
        repeat (2) @(posedge clk);
        chk(tc, 8'h5A);
        ce <= 1'b1;
        @(posedge clk);
        rchk(TS, 8'h00);
        chk(tc, 8'h00);
        $display("test register test done");
        test_done;
    end
endmodule // test_flash_program_erase_control
